// ===== src/bbu_pkg.sv
// constants shared by the branch test and boolean unit
package bbu_pkg;
	// operand widths
	localparam int WORD_W = 60;
	localparam int INDEX_W = 18;
	localparam int FM_W = 6;
	localparam int DESIG_W = 3;
	localparam int PARCEL_W = 2;
	localparam int FUNC_W = 3;
	localparam int EXP_TOP = 59;
	localparam int EXP_BOT = 48;
	localparam int IDX_SIGN = 17;

	// major function codes of the handled instructions
	localparam logic [FM_W-1:0] FM_XBRANCH = 6'h03;
	localparam logic [FM_W-1:0] FM_BR_EQ = 6'h04;
	localparam logic [FM_W-1:0] FM_BR_NE = 6'h05;
	localparam logic [FM_W-1:0] FM_BR_GE = 6'h06;
	localparam logic [FM_W-1:0] FM_BR_LT = 6'h07;
	localparam logic [FM_W-1:0] FM_XMIT = 6'h08;
	localparam logic [FM_W-1:0] FM_AND = 6'h09;
	localparam logic [FM_W-1:0] FM_OR = 6'h0a;
	localparam logic [FM_W-1:0] FM_XOR = 6'h0b;
	localparam logic [FM_W-1:0] FM_CPL = 6'h0c;
	localparam logic [FM_W-1:0] FM_ANDN = 6'h0d;

	// sub codes under the operand-word branch code
	localparam logic [DESIG_W-1:0] SUB_DEFINITE = 3'h6;
	localparam logic [DESIG_W-1:0] SUB_INDEFINITE = 3'h7;

	// top four octal digits of an indefinite operand
	localparam logic [EXP_TOP-EXP_BOT:0] EXP_POS_INDEF = 12'h3ff;
	localparam logic [EXP_TOP-EXP_BOT:0] EXP_NEG_INDEF = 12'hc00;

	// parcel where fetching resumes after a taken branch
	localparam logic [PARCEL_W-1:0] PARCEL_ZERO = 2'h0;

	// boolean unit function select
	localparam logic [FUNC_W-1:0] FN_XMIT = 3'h0;
	localparam logic [FUNC_W-1:0] FN_AND = 3'h1;
	localparam logic [FUNC_W-1:0] FN_OR = 3'h2;
	localparam logic [FUNC_W-1:0] FN_XOR = 3'h3;
	localparam logic [FUNC_W-1:0] FN_CPL = 3'h4;
	localparam logic [FUNC_W-1:0] FN_ANDN = 3'h5;

	// reset values
	localparam logic [WORD_W-1:0] WORD_RST = 60'h0;
	localparam logic [INDEX_W-1:0] INDEX_RST = 18'h0_0000;
endpackage : bbu_pkg

// ===== src/bbu_logic_unit.sv
// 60-bit boolean function unit with registered result
`timescale 1ns/1ns
module bbu_logic_unit
	import bbu_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_valid,
	input wire logic [bbu_pkg::FUNC_W-1:0] i_func,
	input wire logic [bbu_pkg::WORD_W-1:0] i_operand_word_source_a,
	input wire logic [bbu_pkg::WORD_W-1:0] i_operand_word_source_b,
	output logic [bbu_pkg::WORD_W-1:0] o_operand_word_destination,
	output logic o_valid
);
	import bbu_pkg::*;

	logic [WORD_W-1:0] result_next;

	// bitwise function of the two source words
	always_comb begin
		unique case (i_func)
			FN_XMIT: result_next = i_operand_word_source_a;
			FN_AND: result_next = i_operand_word_source_a & i_operand_word_source_b;
			FN_OR: result_next = i_operand_word_source_a | i_operand_word_source_b;
			FN_XOR: result_next = i_operand_word_source_a ^ i_operand_word_source_b;
			FN_CPL: result_next = ~i_operand_word_source_b;
			FN_ANDN: result_next = i_operand_word_source_a & ~i_operand_word_source_b;
			default: result_next = i_operand_word_source_a;
		endcase
	end

	// result register, held until the next valid request
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_operand_word_destination <= WORD_RST;
		end else if (i_valid) begin
			o_operand_word_destination <= result_next;
		end
	end

	// one-cycle completion strobe
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_valid <= 1'b0;
		end else begin
			o_valid <= i_valid;
		end
	end
endmodule : bbu_logic_unit

// ===== src/bbu_branch_bool.sv
// branch test and boolean unit: branch decisions and 60-bit logic ops
//
// Functional notes
// - branches are two parcels; low 18 bits are K, the jump address
// - definite test continues only on exponent 1777 or 6000, else jumps
// - indefinite test jumps only on exponent 1777 or 6000, else continues
// - indefinite tests ignore coefficient; overflow and underflow count defined
// - with stack fitted, a taken branch outside the stack voids it
// - index equal branch jumps only on exact bit match
// - index unequal branch continues only on exact bit match
// - all zeros and all ones compare unequal
// - signed first >= second jumps, else continues
// - signed first < second jumps, else continues
// - positive zero orders above negative zero
// - transmit copies source a unchanged to destination
// - product writes bitwise and of both sources
// - sum writes bitwise or of both sources
// - difference writes bitwise xor of both sources
// - complement writes inverted source b
// - masked product writes a and not b
// - index sign is bit 17
`timescale 1ns/1ns
module bbu_branch_bool
	import bbu_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_issue_valid,
	input wire logic [bbu_pkg::FM_W-1:0] i_fm,
	input wire logic [bbu_pkg::DESIG_W-1:0] i_desig,
	input wire logic [bbu_pkg::WORD_W-1:0] i_operand_word_source_a,
	input wire logic [bbu_pkg::WORD_W-1:0] i_operand_word_source_b,
	input wire logic [bbu_pkg::INDEX_W-1:0] i_index_register_first,
	input wire logic [bbu_pkg::INDEX_W-1:0] i_index_register_second,
	input wire logic [bbu_pkg::INDEX_W-1:0] i_k,
	input wire logic i_stack_fitted,
	input wire logic [bbu_pkg::INDEX_W-1:0] i_stack_low,
	input wire logic [bbu_pkg::INDEX_W-1:0] i_stack_high,
	output logic o_branch_done,
	output logic o_branch_taken,
	output logic [bbu_pkg::INDEX_W-1:0] o_jump_address,
	output logic [bbu_pkg::PARCEL_W-1:0] o_fetch_parcel,
	output logic o_discard_parcels,
	output logic o_stack_void,
	output logic [bbu_pkg::WORD_W-1:0] o_operand_word_destination,
	output logic o_result_valid,
	output logic o_unhandled
);
	import bbu_pkg::*;

	// exponent field check for indefinite operands, coefficient unused
	function automatic logic fp_indefinite(input logic [WORD_W-1:0] w);
		logic [EXP_TOP-EXP_BOT:0] e;
		e = w[EXP_TOP:EXP_BOT];
		return (e == EXP_POS_INDEF) || (e == EXP_NEG_INDEF);
	endfunction : fp_indefinite

	// signed index order, sign taken from the top bit
	function automatic logic idx_ge(input logic [INDEX_W-1:0] a, input logic [INDEX_W-1:0] b);
		logic sa;
		logic sb;
		sa = a[IDX_SIGN];
		sb = b[IDX_SIGN];
		// two's-complement view puts all ones below all zeros
		if (sa != sb) begin
			return sb;
		end
		return a >= b;
	endfunction : idx_ge

	// k address lies inside the held stack window
	function automatic logic in_stack(input logic [INDEX_W-1:0] k,
		input logic [INDEX_W-1:0] lo, input logic [INDEX_W-1:0] hi);
		return (k >= lo) && (k <= hi);
	endfunction : in_stack

	logic is_def;
	logic is_indef;
	logic is_eq;
	logic is_ne;
	logic is_ge;
	logic is_lt;
	logic is_branch;
	logic is_bool;
	logic take_next;
	logic [FUNC_W-1:0] func_sel;
	logic idx_same;
	logic indef;

	// instruction decode
	assign is_def = (i_fm == FM_XBRANCH) && (i_desig == SUB_DEFINITE);
	assign is_indef = (i_fm == FM_XBRANCH) && (i_desig == SUB_INDEFINITE);
	assign is_eq = (i_fm == FM_BR_EQ);
	assign is_ne = (i_fm == FM_BR_NE);
	assign is_ge = (i_fm == FM_BR_GE);
	assign is_lt = (i_fm == FM_BR_LT);
	assign is_branch = is_def | is_indef | is_eq | is_ne | is_ge | is_lt;
	assign is_bool = (i_fm >= FM_XMIT) && (i_fm <= FM_ANDN);

	// operand tests
	assign indef = fp_indefinite(i_operand_word_source_a);
	assign idx_same = (i_index_register_first == i_index_register_second);

	// taken decision for the current branch
	always_comb begin
		take_next = 1'b0;
		if (is_def) begin
			take_next = !indef;
		end else if (is_indef) begin
			take_next = indef;
		end else if (is_eq) begin
			take_next = idx_same;
		end else if (is_ne) begin
			take_next = !idx_same;
		end else if (is_ge) begin
			take_next = idx_ge(i_index_register_first, i_index_register_second);
		end else if (is_lt) begin
			take_next = !idx_ge(i_index_register_first, i_index_register_second);
		end
	end

	// map the function code to the boolean unit select
	always_comb begin
		unique case (i_fm)
			FM_AND: func_sel = FN_AND;
			FM_OR: func_sel = FN_OR;
			FM_XOR: func_sel = FN_XOR;
			FM_CPL: func_sel = FN_CPL;
			FM_ANDN: func_sel = FN_ANDN;
			default: func_sel = FN_XMIT;
		endcase
	end

	// branch completion and decision strobes
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_branch_done <= 1'b0;
			o_branch_taken <= 1'b0;
			o_discard_parcels <= 1'b0;
		end else begin
			o_branch_done <= i_issue_valid && is_branch;
			o_branch_taken <= i_issue_valid && is_branch && take_next;
			o_discard_parcels <= i_issue_valid && is_branch && take_next;
		end
	end

	// jump address from the low 18 bits, fetch restarts at parcel zero
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_jump_address <= INDEX_RST;
			o_fetch_parcel <= PARCEL_ZERO;
		end else if (i_issue_valid && is_branch) begin
			o_jump_address <= i_k;
			o_fetch_parcel <= PARCEL_ZERO;
		end
	end

	// stack invalidation when the target leaves the stack
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_stack_void <= 1'b0;
		end else begin
			o_stack_void <= i_issue_valid && is_branch && take_next && i_stack_fitted
				&& !in_stack(i_k, i_stack_low, i_stack_high);
		end
	end

	// codes outside this unit's group
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_unhandled <= 1'b0;
		end else begin
			o_unhandled <= i_issue_valid && !is_branch && !is_bool;
		end
	end

	// boolean datapath
	bbu_logic_unit u_logic (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_valid(i_issue_valid && is_bool),
		.i_func(func_sel),
		.i_operand_word_source_a(i_operand_word_source_a),
		.i_operand_word_source_b(i_operand_word_source_b),
		.o_operand_word_destination(o_operand_word_destination),
		.o_valid(o_result_valid)
	);

	// checks on the registered decisions
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	a_definite_branch: assert property (
		i_issue_valid && is_def |=> o_branch_done
			&& (o_branch_taken == !fp_indefinite($past(i_operand_word_source_a))))
		else $error("definite branch decision wrong");

	a_indefinite_branch: assert property (
		i_issue_valid && is_indef && (i_operand_word_source_a[EXP_TOP:EXP_BOT] == EXP_NEG_INDEF)
			|=> o_branch_taken)
		else $error("negative indefinite not taken");

	a_overflow_defined: assert property (
		i_issue_valid && is_indef && (i_operand_word_source_a[EXP_TOP:EXP_BOT] == 12'h7ff)
			|=> o_branch_done && !o_branch_taken)
		else $error("overflow treated as indefinite");

	a_equal_exact: assert property (
		i_issue_valid && is_eq |=> (o_branch_taken
			== ($past(i_index_register_first) == $past(i_index_register_second))))
		else $error("equality branch wrong");

	a_zero_ones_unequal: assert property (
		i_issue_valid && is_ne && (i_index_register_first == INDEX_RST)
			&& (i_index_register_second == ~INDEX_RST) |=> o_branch_taken)
		else $error("zero and all ones compared equal");

	a_signed_ge: assert property (
		i_issue_valid && is_ge |=> (o_branch_taken == ($signed($past(i_index_register_first))
			>= $signed($past(i_index_register_second)))))
		else $error("signed ge branch wrong");

	a_signed_lt: assert property (
		i_issue_valid && is_lt |=> (o_branch_taken == ($signed($past(i_index_register_first))
			< $signed($past(i_index_register_second)))))
		else $error("signed lt branch wrong");

	a_target_parcel: assert property (
		o_branch_taken |-> o_discard_parcels && (o_fetch_parcel == PARCEL_ZERO)
			&& (o_jump_address == $past(i_k)))
		else $error("taken branch fetch target wrong");

	a_stack_void_cause: assert property (
		o_stack_void |-> o_branch_taken && $past(i_stack_fitted))
		else $error("stack voided without taken branch");

	a_product_result: assert property (
		i_issue_valid && (i_fm == FM_AND) |=> o_result_valid && (o_operand_word_destination
			== ($past(i_operand_word_source_a) & $past(i_operand_word_source_b))))
		else $error("logical product wrong");

	a_masked_result: assert property (
		i_issue_valid && (i_fm == FM_ANDN) |=> o_result_valid && (o_operand_word_destination
			== ($past(i_operand_word_source_a) & ~$past(i_operand_word_source_b))))
		else $error("masked product wrong");

	a_unequal_exact: assert property (
		i_issue_valid && is_ne |=> o_branch_done && (o_branch_taken
			== ($past(i_index_register_first) != $past(i_index_register_second))))
		else $error("inequality branch wrong");

	a_zero_order: assert property (
		i_issue_valid && is_ge && (i_index_register_first == INDEX_RST)
			&& (i_index_register_second == ~INDEX_RST) |=> o_branch_taken)
		else $error("positive zero not above negative zero");

	a_index_sign: assert property (
		i_issue_valid && is_lt && i_index_register_first[IDX_SIGN]
			&& !i_index_register_second[IDX_SIGN] |=> o_branch_taken)
		else $error("index sign not from top bit");

	a_jump_target: assert property (
		i_issue_valid && is_branch |=> o_branch_done && (o_jump_address == $past(i_k)))
		else $error("jump address not taken from k");

	a_indef_positive: assert property (
		i_issue_valid && is_indef && (i_operand_word_source_a[EXP_TOP:EXP_BOT] == EXP_POS_INDEF)
			|=> o_branch_taken)
		else $error("positive indefinite not taken");

	a_definite_overflow: assert property (
		i_issue_valid && is_def && (i_operand_word_source_a[EXP_TOP:EXP_BOT] == 12'h800)
			|=> o_branch_taken)
		else $error("negative overflow treated as indefinite");

	a_stack_void_set: assert property (
		o_branch_taken && $past(i_stack_fitted) && (($past(i_k) < $past(i_stack_low))
			|| ($past(i_k) > $past(i_stack_high))) |-> o_stack_void)
		else $error("stack kept on jump outside it");

	a_stack_void_window: assert property (
		o_stack_void |-> ($past(i_k) < $past(i_stack_low)) || ($past(i_k) > $past(i_stack_high)))
		else $error("stack voided for target inside it");

	a_discard_taken: assert property (
		o_discard_parcels |-> o_branch_taken)
		else $error("parcels dropped without taken branch");

	a_transmit_result: assert property (
		i_issue_valid && (i_fm == FM_XMIT) |=> o_result_valid
			&& (o_operand_word_destination == $past(i_operand_word_source_a)))
		else $error("transmit result wrong");

	a_sum_result: assert property (
		i_issue_valid && (i_fm == FM_OR) |=> o_result_valid && (o_operand_word_destination
			== ($past(i_operand_word_source_a) | $past(i_operand_word_source_b))))
		else $error("logical sum wrong");

	a_difference_result: assert property (
		i_issue_valid && (i_fm == FM_XOR) |=> o_result_valid && (o_operand_word_destination
			== ($past(i_operand_word_source_a) ^ $past(i_operand_word_source_b))))
		else $error("logical difference wrong");

	a_complement_result: assert property (
		i_issue_valid && (i_fm == FM_CPL) |=> o_result_valid
			&& (o_operand_word_destination == ~$past(i_operand_word_source_b)))
		else $error("complement result wrong");
endmodule : bbu_branch_bool

// ===== verif/bbu_issue_model.sv
// issue-side model that presents one instruction per call to the unit
`timescale 1ns/1ns
module bbu_issue_model
	import bbu_pkg::*;
(
	input wire logic i_core_clk,
	output logic o_issue_valid,
	output logic [bbu_pkg::FM_W-1:0] o_fm,
	output logic [bbu_pkg::DESIG_W-1:0] o_desig,
	output logic [bbu_pkg::WORD_W-1:0] o_word_a,
	output logic [bbu_pkg::WORD_W-1:0] o_word_b,
	output logic [bbu_pkg::INDEX_W-1:0] o_first,
	output logic [bbu_pkg::INDEX_W-1:0] o_second,
	output logic [bbu_pkg::INDEX_W-1:0] o_k
);
	import bbu_pkg::*;

	// quiet request lines at time zero
	initial begin
		o_issue_valid = 1'b0;
		o_fm = 6'h00;
		o_desig = 3'h0;
		o_word_a = WORD_RST;
		o_word_b = WORD_RST;
		o_first = INDEX_RST;
		o_second = INDEX_RST;
		o_k = INDEX_RST;
	end

	// called just after an edge; holds the request through the taking edge
	task automatic send(input logic [FM_W-1:0] fm, input logic [DESIG_W-1:0] d,
		input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b,
		input logic [INDEX_W-1:0] f, input logic [INDEX_W-1:0] s, input logic [INDEX_W-1:0] k);
		o_issue_valid = 1'b1;
		o_fm = fm;
		o_desig = d;
		o_word_a = a;
		o_word_b = b;
		o_first = f;
		o_second = s;
		o_k = k;
		@(posedge i_core_clk);
		#1;
	endtask : send

	// strobe low across one edge; operands flip so stale values never look held
	task automatic idle();
		o_issue_valid = 1'b0;
		o_word_a = ~o_word_a;
		o_word_b = ~o_word_b;
		o_first = ~o_first;
		o_second = ~o_second;
		o_k = ~o_k;
		@(posedge i_core_clk);
		#1;
	endtask : idle
endmodule : bbu_issue_model

// ===== verif/bbu_branch_bool_tb.sv
// self-checking bench for the branch test and boolean unit
`timescale 1ns/1ns
module bbu_branch_bool_tb;
	import bbu_pkg::*;
	logic i_core_clk, i_rst, stack_fitted, valid;
	logic [FM_W-1:0] fm;
	logic [DESIG_W-1:0] desig;
	logic [WORD_W-1:0] wa, wb, dest;
	logic [INDEX_W-1:0] first, second, k, stack_low, stack_high, jump_addr;
	logic [PARCEL_W-1:0] parcel;
	logic done, taken, discard, void_s, res_valid, unhandled;
	int n_errors = 0;
	int comparisons = 0;

	bbu_issue_model pm (.i_core_clk(i_core_clk), .o_issue_valid(valid), .o_fm(fm),
		.o_desig(desig), .o_word_a(wa), .o_word_b(wb), .o_first(first), .o_second(second), .o_k(k));
	bbu_branch_bool uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_issue_valid(valid),
		.i_fm(fm), .i_desig(desig), .i_operand_word_source_a(wa), .i_operand_word_source_b(wb),
		.i_index_register_first(first), .i_index_register_second(second), .i_k(k),
		.i_stack_fitted(stack_fitted), .i_stack_low(stack_low), .i_stack_high(stack_high),
		.o_branch_done(done), .o_branch_taken(taken), .o_jump_address(jump_addr),
		.o_fetch_parcel(parcel), .o_discard_parcels(discard), .o_stack_void(void_s),
		.o_operand_word_destination(dest), .o_result_valid(res_valid), .o_unhandled(unhandled));

	// 10 MHz clock
	always #50 i_core_clk = ~i_core_clk;

	task automatic chk(input logic ok, input string what);
		comparisons++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask : chk

	// one branch; expected void worked out from the stack window
	task automatic br(input logic [FM_W-1:0] f, input logic [DESIG_W-1:0] d,
		input logic [WORD_W-1:0] a, input logic [INDEX_W-1:0] x, input logic [INDEX_W-1:0] y,
		input logic [INDEX_W-1:0] kk, input logic t);
		logic v;
		v = t & stack_fitted & ((kk < stack_low) | (kk > stack_high));
		pm.send(f, d, a, ~a, x, y, kk);
		chk(done === 1'b1 && taken === t && discard === t && jump_addr === kk
			&& parcel === PARCEL_ZERO && void_s === v && res_valid === 1'b0, "branch");
	endtask : br

	task automatic bl(input logic [FM_W-1:0] f, input logic [WORD_W-1:0] a,
		input logic [WORD_W-1:0] b, input logic [WORD_W-1:0] e);
		pm.send(f, 3'h0, a, b, INDEX_RST, INDEX_RST, INDEX_RST);
		chk(res_valid === 1'b1 && done === 1'b0 && dest === e, "boolean result");
	endtask : bl

	// word tests on exponent field, coefficient varied, window edges for void
	task automatic s_word();
		br(FM_XBRANCH, SUB_DEFINITE, {12'h3ff, 48'hffff_ffff_ffff}, 0, 0, 18'h0_0150, 0);
		br(FM_XBRANCH, SUB_DEFINITE, {12'hc00, 48'h0000_0000_0000}, 0, 0, 18'h0_0150, 0);
		br(FM_XBRANCH, SUB_DEFINITE, {12'h3fe, 48'h0000_0000_0000}, 0, 0, 18'h0_0150, 1);
		br(FM_XBRANCH, SUB_DEFINITE, {12'h7ff, 48'h8000_0000_0001}, 0, 0, 18'h0_0050, 1);
		br(FM_XBRANCH, SUB_DEFINITE, {12'h800, 48'h1234_5678_9abc}, 0, 0, 18'h0_01ff, 1);
		br(FM_XBRANCH, SUB_DEFINITE, {12'h000, 48'h0000_0000_0001}, 0, 0, 18'h0_0150, 1);
		br(FM_XBRANCH, SUB_INDEFINITE, {12'h3ff, 48'h0000_0000_0000}, 0, 0, 18'h0_0200, 1);
		br(FM_XBRANCH, SUB_INDEFINITE, {12'hc00, 48'hffff_ffff_ffff}, 0, 0, 18'h0_0100, 1);
		br(FM_XBRANCH, SUB_INDEFINITE, {12'h7ff, 48'h0000_0000_0000}, 0, 0, 18'h0_0150, 0);
		br(FM_XBRANCH, SUB_INDEFINITE, {12'hc01, 48'h0000_0000_0000}, 0, 0, 18'h0_0150, 0);
		stack_fitted = 1'b0;
		br(FM_XBRANCH, SUB_INDEFINITE, {12'h000, 48'h0000_0000_0000}, 0, 0, 18'h0_0150, 0);
		br(FM_XBRANCH, SUB_DEFINITE, {12'h000, 48'h0000_0000_0000}, 0, 0, 18'h3_ffff, 1);
		stack_fitted = 1'b1;
		pm.idle();
	endtask : s_word

	task automatic s_index_eq();
		br(FM_BR_EQ, 3'h0, WORD_RST, 18'h1_2345, 18'h1_2345, 18'h0_0150, 1);
		br(FM_BR_EQ, 3'h0, WORD_RST, 18'h1_2345, 18'h1_2344, 18'h0_0150, 0);
		br(FM_BR_EQ, 3'h0, WORD_RST, 18'h0_0000, 18'h3_ffff, 18'h0_0150, 0);
		br(FM_BR_NE, 3'h0, WORD_RST, 18'h3_ffff, 18'h3_ffff, 18'h0_0150, 0);
		br(FM_BR_NE, 3'h0, WORD_RST, 18'h0_0000, 18'h3_ffff, 18'h0_0250, 1);
		pm.idle();
	endtask : s_index_eq

	task automatic s_index_order();
		br(FM_BR_GE, 3'h0, WORD_RST, 18'h0_0000, 18'h3_ffff, 18'h0_0150, 1);
		br(FM_BR_LT, 3'h0, WORD_RST, 18'h0_0000, 18'h3_ffff, 18'h0_0150, 0);
		br(FM_BR_LT, 3'h0, WORD_RST, 18'h3_ffff, 18'h0_0000, 18'h0_0150, 1);
		br(FM_BR_GE, 3'h0, WORD_RST, 18'h1_ffff, 18'h2_0000, 18'h0_0150, 1);
		br(FM_BR_LT, 3'h0, WORD_RST, 18'h2_0000, 18'h1_ffff, 18'h0_0150, 1);
		br(FM_BR_GE, 3'h0, WORD_RST, 18'h0_0004, 18'h0_0005, 18'h0_0150, 0);
		br(FM_BR_GE, 3'h0, WORD_RST, 18'h0_0005, 18'h0_0005, 18'h0_0150, 1);
		br(FM_BR_LT, 3'h0, WORD_RST, 18'h0_0005, 18'h0_0005, 18'h0_0150, 0);
		pm.idle();
	endtask : s_index_order

	// all six boolean forms back to back on the four bit combinations
	task automatic s_bool();
		logic [WORD_W-1:0] a, b;
		a = 60'hf0f_00ff_1234_5678;
		b = 60'h0ff_0f0f_ffff_0000;
		bl(FM_XMIT, a, b, a);
		bl(FM_AND, a, b, a & b);
		bl(FM_OR, a, b, a | b);
		bl(FM_XOR, a, b, a ^ b);
		bl(FM_CPL, a, b, ~b);
		bl(FM_ANDN, a, b, a & ~b);
		pm.idle();
		chk(res_valid === 1'b0 && dest === (a & ~b), "result held after pulse");
	endtask : s_bool

	// code outside the group, then a reset in mid-run
	task automatic s_misc();
		pm.send(6'h0e, 3'h0, WORD_RST, WORD_RST, INDEX_RST, INDEX_RST, INDEX_RST);
		chk(unhandled === 1'b1 && done === 1'b0 && res_valid === 1'b0, "unknown code");
		pm.idle();
		i_rst = 1'b1;
		@(posedge i_core_clk);
		#1;
		chk(dest === WORD_RST && jump_addr === INDEX_RST && taken === 1'b0, "mid-run reset");
		i_rst = 1'b0;
		br(FM_BR_EQ, 3'h0, WORD_RST, 18'h0_0007, 18'h0_0007, 18'h0_0180, 1);
		pm.idle();
	endtask : s_misc

	task automatic report_and_stop();
		if (n_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	// hang guard
	initial begin
		repeat (2000) @(posedge i_core_clk);
		n_errors++;
		report_and_stop();
	end

	// main sequence
	initial begin
		i_core_clk = 1'b0;
		i_rst = 1'b1;
		stack_fitted = 1'b1;
		stack_low = 18'h0_0100;
		stack_high = 18'h0_01ff;
		repeat (8) @(posedge i_core_clk);
		#1;
		i_rst = 1'b0;
		chk(done === 1'b0 && dest === WORD_RST && parcel === PARCEL_ZERO, "reset values");
		s_word();
		s_index_eq();
		s_index_order();
		s_bool();
		s_misc();
		report_and_stop();
	end
endmodule : bbu_branch_bool_tb
